/* src/nvac_defines.svh */
`ifndef NVAC_DEFINES_SVH
`define NVAC_DEFINES_SVH

// register byte offsets on the bus
`define NVAC_OFS_ADR_LO   8'h00
`define NVAC_OFS_ADR_HI   8'h04
`define NVAC_OFS_DAT_LO   8'h08
`define NVAC_OFS_DAT_HI   8'h0C
`define NVAC_OFS_CTL      8'h10
`define NVAC_OFS_UNLOCK   8'h14
`define NVAC_OFS_STATUS   8'h18
`define NVAC_OFS_MASK     8'h1C

// control register fields
`define NVAC_BIT_SPACE    7
`define NVAC_BIT_ABORT    3
`define NVAC_BIT_PERMIT   2
`define NVAC_BIT_WR       1
`define NVAC_BIT_RD       0

// status and mask fields
`define NVAC_IRQ_DONE     0
`define NVAC_IRQ_ABORT    1
`define NVAC_IRQ_RDONE    2

// unlock keys
`define NVAC_KEY1         8'h55
`define NVAC_KEY2         8'hAA

// reset values
`define NVAC_RST_BYTE     8'h00
`define NVAC_RST_IRQ      3'h0

// timing
`define NVAC_CLK_NS       20
`define NVAC_WR_TIME_NS   320
`define NVAC_WR_CYCLES \
  ((`NVAC_WR_TIME_NS + `NVAC_CLK_NS - 1) / `NVAC_CLK_NS)

`endif

/* src/nvac_pkg.sv */
package nvac_pkg;

  typedef enum logic [5:0] {
    S_IDLE  = 6'h01,
    S_DLOAD = 6'h02,
    S_PSKIP = 6'h04,
    S_PACC  = 6'h08,
    S_PLOAD = 6'h10,
    S_WRITE = 6'h20
  } nvac_state_e;

  typedef enum logic [2:0] {
    U_IDLE  = 3'h1,
    U_GOT1  = 3'h2,
    U_ARMED = 3'h4
  } nvac_unl_e;

endpackage : nvac_pkg

/* src/nvac_if.sv */
`timescale 1ns/1ps
interface nvac_if;
  logic       acc;
  logic       unl_wr;
  logic [7:0] wdata;
  logic       armed;
  logic       mem_re;
  logic       mem_we;
  logic [7:0] mem_addr;
  logic [7:0] mem_wdata;
  logic [7:0] mem_rdata;

  modport ctl (output acc, unl_wr, wdata, mem_re, mem_we, mem_addr,
               mem_wdata, input armed, mem_rdata);
  modport unl (input acc, unl_wr, wdata, output armed);
  modport mem (input mem_re, mem_we, mem_addr, mem_wdata,
               output mem_rdata);
endinterface : nvac_if

/* src/nvac_unlock.sv */
`timescale 1ns/1ps
`include "nvac_defines.svh"
module nvac_unlock
  import nvac_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // link to the controller
  nvac_if.unl      lnk
);

  typedef struct packed {
    nvac_unl_e state;
  } nvac_unl_s;

  nvac_unl_s st;
  nvac_unl_s next_st;

  // any other access between the steps drops back to idle
  always_comb begin
    next_st = st;
    if (lnk.acc) begin
      case (st.state)
        U_IDLE: begin
          if (lnk.unl_wr && lnk.wdata == `NVAC_KEY1)
            next_st.state = U_GOT1;
        end
        U_GOT1: begin
          if (lnk.unl_wr && lnk.wdata == `NVAC_KEY2)
            next_st.state = U_ARMED;
          else
            next_st.state = U_IDLE;
        end
        default: next_st.state = U_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) st.state <= U_IDLE;
    else        st <= next_st;
  end

  assign lnk.armed = (st.state == U_ARMED);

  chk_unlock_drop: assert property (@(posedge mclk) disable iff (!rst_n)
    lnk.acc && !lnk.unl_wr |=> st.state == U_IDLE)
    else $error("unlock state survived a foreign access");
  cov_unlock_armed: cover property (@(posedge mclk) disable iff (!rst_n)
    st.state == U_GOT1 ##1 st.state == U_ARMED);

endmodule : nvac_unlock

/* src/nvac_mem.sv */
`timescale 1ns/1ps
module nvac_mem #(
  parameter int DEPTH = 256
) (
  // clock
  input wire logic mclk,
  // port from the controller
  nvac_if.mem      port
);

  logic [7:0] cells [DEPTH];
  logic [7:0] rdata;

  // no reset: cell contents are nonvolatile, read data is a register
  always_ff @(posedge mclk) begin
    if (port.mem_we) cells[port.mem_addr] <= port.mem_wdata;
    if (port.mem_re) rdata <= cells[port.mem_addr];
  end

  assign port.mem_rdata = rdata;

endmodule : nvac_mem

/* src/nvac_ctrl.sv */
// Overview of operation
// - data read: address, space bit clear, read strobe; byte next cycle
// - low data keeps its value until another read or a software write
// - a byte write starts only after 55h, AAh to unlock, then write strobe
// - write strobe cannot be set unless write permit is already set
// - hardware never clears write permit; only software changes it
// - a started write finishes even if permit is cleared meanwhile
// - write end clears the write strobe and sets the complete flag
// - the complete flag stays set until software clears it
// - flash read: both address bytes, space bit set, read strobe
// - flash is accessed in the second cycle; that fetch is discarded
// - flash word lands in both data registers after access and stays
// - write strobe with space bit set is dropped, nothing happens
// - abort flag set when a write is cut short by a reset cause
// - hardware clears the read strobe; software can only set it
//
// The AHB-Lite interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "nvac_defines.svh"
module nvac_ctrl
  import nvac_pkg::*;
#(
  parameter int FLASH_AW  = 13,
  parameter int FLASH_DW  = 14,
  parameter int EE_DEPTH  = 256,
  parameter int WR_CYCLES = `NVAC_WR_CYCLES
) (
  // clock and reset
  input  wire logic                mclk,
  input  wire logic                reset_n,
  // ahb-lite slave
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic                     hreadyout,
  output logic                     hresp,
  output logic [31:0]              hrdata,
  // interrupt
  output logic                     irq,
  // program flash read port
  output logic [FLASH_AW-1:0]      flash_addr,
  output logic                     flash_rd,
  input  wire logic [FLASH_DW-1:0] flash_rdata,
  // core side
  output logic                     fetch_squash,
  input  wire logic                abort_pin
);

  localparam int HW = FLASH_AW - 8;
  localparam int DW = FLASH_DW - 8;

  typedef struct packed {
    logic [2:0]  asy;
    logic        abort_lvl;
    logic        pend;
    logic        pwr;
    logic        pok;
    logic [2:0]  pidx;
    logic        hready;
    logic [31:0] hrdata;
    logic        irq;
    logic [7:0]  adr_lo;
    logic [HW-1:0] adr_hi;
    logic [7:0]  dat_lo;
    logic [DW-1:0] dat_hi;
    logic        space;
    logic        write_abort_flag;
    logic        permit;
    logic        wr;
    logic        rd;
    logic [2:0]  status;
    logic [2:0]  mask;
    nvac_state_e state;
    logic [15:0] cnt;
    logic [FLASH_AW-1:0] faddr;
    logic        frd;
    logic        squash;
  } nvac_ctl_s;

  localparam nvac_ctl_s RST = '{state: S_IDLE, hready: 1'b1,
                                default: '0};

  nvac_ctl_s   st;
  nvac_ctl_s   next_st;
  logic [1:0]  rsync;
  logic        rst_n;
  logic        acc;
  logic        dwr;
  logic        drd;
  logic [7:0]  wd;
  logic        ctl_w;
  logic        abort_ev;
  logic        mem_re;
  logic        mem_we;

  nvac_if lnk ();

  nvac_unlock u_unlock (
    .mclk  (mclk),
    .rst_n (rst_n),
    .lnk   (lnk.unl)
  );

  nvac_mem #(.DEPTH(EE_DEPTH)) u_mem (
    .mclk (mclk),
    .port (lnk.mem)
  );

  // reset is released on the clock, asserted at once
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) rsync <= 2'h0;
    else          rsync <= {rsync[0], 1'b1};
  end
  assign rst_n = rsync[1];

  // word index match; every register sits on its own aligned word
  function automatic logic hit(input logic [2:0] idx,
                               input logic [7:0] ofs);
    return idx == ofs[4:2];
  endfunction : hit

  // every transfer takes one wait state; the access acts at its end
  assign acc   = st.pend && st.pok;
  assign dwr   = acc && st.pwr;
  assign drd   = acc && !st.pwr;
  assign wd    = hwdata[7:0];
  assign ctl_w = dwr && hit(st.pidx, `NVAC_OFS_CTL);

  // pin rise counts once the second and third stages agree on a high level
  assign abort_ev = (st.asy[1] == st.asy[2]) && st.asy[2]
                    && !st.abort_lvl;

  assign lnk.acc       = acc;
  assign lnk.unl_wr    = dwr && hit(st.pidx, `NVAC_OFS_UNLOCK);
  assign lnk.wdata     = wd;
  assign lnk.mem_re    = mem_re;
  assign lnk.mem_we    = mem_we;
  assign lnk.mem_addr  = st.adr_lo;
  assign lnk.mem_wdata = st.dat_lo;

  always_comb begin
    logic [31:0] rv;
    rv      = '0;
    next_st = st;
    mem_re  = 1'b0;
    mem_we  = 1'b0;

    next_st.asy = {st.asy[1:0], abort_pin};
    if (st.asy[1] == st.asy[2]) next_st.abort_lvl = st.asy[2];

    // bus address and data phases
    if (st.pend) begin
      next_st.pend   = 1'b0;
      next_st.hready = 1'b1;
    end else if (hsel && htrans[1] && hready && st.hready) begin
      next_st.pend   = 1'b1;
      next_st.pwr    = hwrite;
      next_st.pok    = (haddr[31:5] == 27'h0000000);
      next_st.pidx   = haddr[4:2];
      next_st.hready = 1'b0;
    end

    // read data; unmapped addresses read as zero
    if (hit(st.pidx, `NVAC_OFS_ADR_LO)) rv[7:0]    = st.adr_lo;
    if (hit(st.pidx, `NVAC_OFS_ADR_HI)) rv[HW-1:0] = st.adr_hi;
    if (hit(st.pidx, `NVAC_OFS_DAT_LO)) rv[7:0]    = st.dat_lo;
    if (hit(st.pidx, `NVAC_OFS_DAT_HI)) rv[DW-1:0] = st.dat_hi;
    if (hit(st.pidx, `NVAC_OFS_CTL)) begin
      rv[`NVAC_BIT_SPACE]  = st.space;
      rv[`NVAC_BIT_ABORT]  = st.write_abort_flag;
      rv[`NVAC_BIT_PERMIT] = st.permit;
      rv[`NVAC_BIT_WR]     = st.wr;
      rv[`NVAC_BIT_RD]     = st.rd;
    end
    if (hit(st.pidx, `NVAC_OFS_STATUS)) rv[2:0] = st.status;
    if (hit(st.pidx, `NVAC_OFS_MASK))   rv[2:0] = st.mask;
    if (st.pend && !st.pwr) next_st.hrdata = st.pok ? rv : 32'h00000000;

    // reading status clears it; later sets in this cycle win
    if (drd && hit(st.pidx, `NVAC_OFS_STATUS)) next_st.status = 3'h0;

    // software writes
    if (dwr && hit(st.pidx, `NVAC_OFS_ADR_LO)) next_st.adr_lo = wd;
    if (dwr && hit(st.pidx, `NVAC_OFS_ADR_HI)) next_st.adr_hi = wd[HW-1:0];
    if (dwr && hit(st.pidx, `NVAC_OFS_DAT_LO)) next_st.dat_lo = wd;
    if (dwr && hit(st.pidx, `NVAC_OFS_DAT_HI)) next_st.dat_hi = wd[DW-1:0];
    if (dwr && hit(st.pidx, `NVAC_OFS_MASK))   next_st.mask = wd[2:0];
    if (ctl_w) begin
      next_st.space  = wd[`NVAC_BIT_SPACE];
      next_st.write_abort_flag = wd[`NVAC_BIT_ABORT];
      next_st.permit = wd[`NVAC_BIT_PERMIT];
      // strobes only set from software; a busy block ignores them
      if (st.state == S_IDLE) begin
        if (wd[`NVAC_BIT_RD]) begin
          next_st.rd = 1'b1;
          if (wd[`NVAC_BIT_SPACE]) begin
            next_st.state = S_PSKIP;
          end else begin
            mem_re        = 1'b1;
            next_st.state = S_DLOAD;
          end
        end else if (wd[`NVAC_BIT_WR] && !wd[`NVAC_BIT_SPACE]
                     && st.permit && lnk.armed) begin
          next_st.wr    = 1'b1;
          next_st.cnt   = 16'(WR_CYCLES - 1);
          next_st.state = S_WRITE;
        end
      end
    end

    case (st.state)
      S_IDLE: begin
      end
      S_DLOAD: begin
        next_st.dat_lo = lnk.mem_rdata;
        next_st.rd     = 1'b0;
        next_st.status[`NVAC_IRQ_RDONE] = 1'b1;
        next_st.state  = S_IDLE;
      end
      S_PSKIP: begin
        // second cycle after the strobe belongs to the flash
        next_st.faddr  = {st.adr_hi, st.adr_lo};
        next_st.frd    = 1'b1;
        next_st.squash = 1'b1;
        next_st.state  = S_PACC;
      end
      S_PACC: begin
        next_st.frd    = 1'b0;
        next_st.squash = 1'b0;
        next_st.state  = S_PLOAD;
      end
      S_PLOAD: begin
        next_st.dat_lo = flash_rdata[7:0];
        next_st.dat_hi = flash_rdata[FLASH_DW-1:8];
        next_st.rd     = 1'b0;
        next_st.status[`NVAC_IRQ_RDONE] = 1'b1;
        next_st.state  = S_IDLE;
      end
      S_WRITE: begin
        // permit is not consulted here, so clearing it cannot stop us
        if (abort_ev) begin
          // the cell is left untouched; a half-written byte is never stored
          next_st.wr    = 1'b0;
          next_st.write_abort_flag = 1'b1;
          next_st.status[`NVAC_IRQ_ABORT] = 1'b1;
          next_st.state = S_IDLE;
        end else if (st.cnt == 16'h0000) begin
          mem_we        = 1'b1;
          next_st.wr    = 1'b0;
          next_st.status[`NVAC_IRQ_DONE] = 1'b1;
          next_st.state = S_IDLE;
        end else begin
          next_st.cnt = st.cnt - 16'h0001;
        end
      end
      default: next_st.state = S_IDLE;
    endcase

    next_st.irq = |(next_st.status & next_st.mask);
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) st <= RST;
    else        st <= next_st;
  end

  assign hreadyout    = st.hready;
  assign hresp        = st.pend && 1'b0;
  assign hrdata       = st.hrdata;
  assign irq          = st.irq;
  assign flash_addr   = st.faddr;
  assign flash_rd     = st.frd;
  assign fetch_squash = st.squash;

  default clocking dc @(posedge mclk); endclocking
  default disable iff (!rst_n);

  chk_data_read_load: assert property (
    st.state == S_DLOAD |=> st.dat_lo == $past(lnk.mem_rdata) && !st.rd)
    else $error("data read did not load low data");
  chk_data_hold: assert property (
    st.state == S_IDLE && !dwr |=> $stable(st.dat_lo))
    else $error("low data changed without read or write");
  chk_wr_unlock: assert property (
    $rose(st.wr) |-> $past(lnk.armed) && $past(ctl_w))
    else $error("write started without unlock sequence");
  chk_wr_permit: assert property (
    $rose(st.wr) |-> $past(st.permit))
    else $error("write strobe set without permit");
  chk_permit_sw: assert property (
    $changed(st.permit) |-> $past(ctl_w))
    else $error("permit changed without software write");
  chk_write_runs: assert property (
    st.state == S_WRITE && st.cnt != 16'h0000 && !abort_ev
    |=> st.state == S_WRITE && st.wr)
    else $error("write cycle cut short");
  chk_done_flag: assert property (
    st.state == S_WRITE && st.cnt == 16'h0000 && !abort_ev
    |=> !st.wr && st.status[`NVAC_IRQ_DONE] && st.state == S_IDLE)
    else $error("write end did not raise complete flag");
  chk_flag_sticky: assert property (
    st.status[`NVAC_IRQ_DONE] && !drd |=> st.status[`NVAC_IRQ_DONE])
    else $error("complete flag dropped by hardware");
  chk_flash_slot: assert property (
    st.state == S_PSKIP |=> flash_rd && fetch_squash ##1 !flash_rd)
    else $error("flash access not in second cycle");
  chk_flash_load: assert property (
    st.state == S_PLOAD |=> {st.dat_hi, st.dat_lo} == $past(flash_rdata))
    else $error("flash word not loaded");
  chk_space_wr: assert property (
    ctl_w && wd[`NVAC_BIT_SPACE] && !st.wr |=> !st.wr)
    else $error("write strobe set with program space");
  chk_abort_flag: assert property (
    st.state == S_WRITE && abort_ev |=> st.write_abort_flag && !st.wr)
    else $error("abort did not raise abort flag");
  chk_abort_clean: assert property (
    st.state == S_WRITE && st.cnt == 16'h0000 && !abort_ev && !ctl_w
    && !st.write_abort_flag |=> !st.write_abort_flag)
    else $error("abort flag set by a completed write");
  chk_one_wait: assert property (
    !st.hready |=> st.hready)
    else $error("bus wait state longer than one cycle");
  chk_rd_clear: assert property (
    $rose(st.rd) |-> ##[1:3] !st.rd)
    else $error("read strobe not cleared by hardware");

  cov_data_read:  cover property (st.state == S_DLOAD);
  cov_flash_read: cover property (st.state == S_PLOAD);
  cov_write_done: cover property ($fell(st.wr) && !st.write_abort_flag);
  cov_write_abrt: cover property (st.state == S_WRITE && abort_ev);

endmodule : nvac_ctrl

/* test/nvac_flash_model.sv */
`timescale 1ns/1ps
module nvac_flash_model #(
  parameter int AW = 13,
  parameter int DW = 14
) (
  // clock
  input  wire logic          mclk,
  // read port
  input  wire logic [AW-1:0] flash_addr,
  input  wire logic          flash_rd,
  output logic      [DW-1:0] flash_rdata
);
  // the word stands only in the cycle after the strobe; otherwise the
  // lines toggle, so a capture on the wrong edge cannot match by chance
  initial flash_rdata = '0;
  always @(posedge mclk) begin
    if (flash_rd === 1'b1) begin
      flash_rdata <= DW'(32'(flash_addr) * 3 + 5);
    end else begin
      flash_rdata <= ~flash_rdata;
    end
  end
endmodule : nvac_flash_model

/* test/eeprom_flash_access_ctrl_tb_top.sv */
`timescale 1ns/1ps
`include "nvac_defines.svh"
module eeprom_flash_access_ctrl_tb_top;
  localparam int         WRC   = 12;
  localparam logic [7:0] A_LO  = `NVAC_OFS_ADR_LO;
  localparam logic [7:0] A_HI  = `NVAC_OFS_ADR_HI;
  localparam logic [7:0] D_LO  = `NVAC_OFS_DAT_LO;
  localparam logic [7:0] D_HI  = `NVAC_OFS_DAT_HI;
  localparam logic [7:0] CTL   = `NVAC_OFS_CTL;
  localparam logic [7:0] UNL   = `NVAC_OFS_UNLOCK;
  localparam logic [7:0] STA   = `NVAC_OFS_STATUS;
  localparam logic [7:0] MSK   = `NVAC_OFS_MASK;
  logic        mclk, reset_n, hsel, hwrite, hready, hreadyout, hresp;
  logic        irq, flash_rd, fetch_squash, abort_pin;
  logic [31:0] haddr, hwdata, hrdata, v;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [12:0] flash_addr, fa;
  logic [13:0] flash_rdata, fw;
  int          failures, checks, rd_cnt, sq_cnt;

  assign hready = hreadyout;

  nvac_ctrl #(.WR_CYCLES(WRC)) i_dut (
    .mclk(mclk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .irq(irq), .flash_addr(flash_addr),
    .flash_rd(flash_rd), .flash_rdata(flash_rdata),
    .fetch_squash(fetch_squash), .abort_pin(abort_pin));

  nvac_flash_model i_flash (
    .mclk(mclk), .flash_addr(flash_addr), .flash_rd(flash_rd),
    .flash_rdata(flash_rdata));

  initial mclk = 1'b0;
  always #10 mclk = ~mclk;

  always @(posedge mclk) begin
    if (flash_rd === 1'b1) begin
      rd_cnt++;
      fa <= flash_addr;
      if (fetch_squash === 1'b1) sq_cnt++;
    end
  end

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: seen %h expected %h",
               $time, seen, exp);
    end
  endtask : chk

  // address phase held until ready is seen, then data phase likewise
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr  <= {24'h000000, a};
    @(posedge mclk);
    while (hready !== 1'b1) @(posedge mclk);
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge mclk);
    while (hready !== 1'b1) @(posedge mclk);
    v = hrdata;
  endtask : bus

  task wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h00000000);
    chk(v, e);
  endtask : rdc

  // no other access between the three steps
  task unlock_go(input logic [31:0] c);
    wr(UNL, 32'h00000055);
    wr(UNL, 32'h000000AA);
    wr(CTL, c);
  endtask : unlock_go

  task wait_idle;
    int n;
    n = 0;
    do begin
      bus(1'b0, CTL, 32'h00000000);
      n++;
    end while (v[1:0] !== 2'b00 && n < 40);
    if (v[1:0] !== 2'b00) failures++;
  endtask : wait_idle

  // fixed settle time taken from the hand-over latencies
  task mem_read(input logic [31:0] c);
    wr(CTL, c);
    repeat (4) @(posedge mclk);
  endtask : mem_read

  task stop_test;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : stop_test

  initial begin
    repeat (20000) @(posedge mclk);
    failures++;
    stop_test();
  end

  initial begin
    reset_n = 1'b0; hsel = 1'b0; htrans = 2'b00; hwrite = 1'b0;
    haddr = '0; hwdata = '0; hsize = 3'b010; abort_pin = 1'b0;
    failures = 0; checks = 0; rd_cnt = 0; sq_cnt = 0;
    repeat (3) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (4) @(posedge mclk);
    rdc(STA, 32'h0);
    chk(32'(irq), 32'h0);
    chk(32'(hresp), 32'h0);
    wr(8'h40, 32'hFFFFFFFF);
    rdc(8'h40, 32'h0);
    wr(A_LO, 32'h12);
    wr(D_LO, 32'hA5);
    unlock_go(32'h02);
    rdc(CTL, 32'h0);
    wr(CTL, 32'h04);
    wr(UNL, 32'hAA);
    wr(UNL, 32'h55);
    wr(CTL, 32'h06);
    rdc(CTL, 32'h04);
    wr(UNL, 32'h55);
    rdc(A_LO, 32'h12);
    wr(UNL, 32'hAA);
    wr(CTL, 32'h06);
    rdc(CTL, 32'h04);
    unlock_go(32'h86);
    rdc(CTL, 32'h84);
    wr(CTL, 32'h04);
    wr(MSK, 32'h01);
    unlock_go(32'h06);
    wait_idle();
    chk(v, 32'h04);
    repeat (5) @(posedge mclk);
    chk(32'(irq), 32'h1);
    rdc(STA, 32'h1);
    repeat (2) @(posedge mclk);
    chk(32'(irq), 32'h0);
    wr(D_LO, 32'h00);
    mem_read(32'h01);
    rdc(D_LO, 32'hA5);
    rdc(CTL, 32'h0);
    rdc(D_LO, 32'hA5);
    wr(D_LO, 32'h3C);
    rdc(D_LO, 32'h3C);
    wr(A_LO, 32'h13);
    wr(D_LO, 32'h5A);
    wr(CTL, 32'h04);
    unlock_go(32'h06);
    wr(CTL, 32'h00);
    wait_idle();
    chk(v, 32'h0);
    mem_read(32'h01);
    rdc(D_LO, 32'h5A);
    rdc(STA, 32'h5);
    wr(A_LO, 32'h12);
    wr(D_LO, 32'hC3);
    wr(CTL, 32'h04);
    unlock_go(32'h06);
    abort_pin <= 1'b1;
    repeat (6) @(posedge mclk);
    abort_pin <= 1'b0;
    wait_idle();
    chk(v, 32'h0C);
    rdc(STA, 32'h2);
    mem_read(32'h01);
    rdc(D_LO, 32'hA5);
    wr(A_HI, 32'h15);
    wr(A_LO, 32'h3C);
    fw = 14'(32'h153C * 3 + 5);
    mem_read(32'h81);
    chk(32'(rd_cnt), 32'h1);
    chk(32'(sq_cnt), 32'h1);
    chk(32'(fa), 32'h153C);
    chk(32'(irq), 32'h0);
    rdc(D_LO, 32'(fw[7:0]));
    rdc(D_HI, 32'(fw[13:8]));
    rdc(CTL, 32'h80);
    wr(CTL, 32'h84);
    unlock_go(32'h86);
    rdc(CTL, 32'h84);
    stop_test();
  end
endmodule : eeprom_flash_access_ctrl_tb_top
